/* File: mpi_ops_defines.svh */
// Opcodes, field widths and timing counts of the multi-word datapath
`ifndef MPI_OPS_DEFINES_SVH
`define MPI_OPS_DEFINES_SVH
`define ADDR_W 16
`define LEN_W 16
`define OP_SHIFT_LEFT 8'h14
`define OP_SHIFT_RIGHT 8'h15
`define OP_ROTATE_LEFT 8'h16
`define OP_ROTATE_RIGHT 8'h17
`define OP_ADD_CONST 8'h1a
`define OP_SUB_CONST 8'h1b
`define OP_AND_CONST 8'h1d
`define OP_OR_CONST 8'h1e
`define OP_XOR_CONST 8'h1f
`define OP_SINGLE_WORD_MULTIPLY 8'h20
`define OP_MULTIPLY_ACCUMULATE_CARRY 8'h22
`define OP_CARRYLESS_WORD_MULTIPLY 8'h24
`define OP_CARRYLESS_MULTIPLY_ACCUMULATE 8'h26
`define CFG_WORD64_A 4'h0
`define CFG_WORD64_B 4'h2
`define WORD_SHIFT 3
`define WORD_BITS 7'h40
`define PHASE_LAST 2'h3
`define CYCLES_PER_WORD_SHIFT 2
`endif

/* File: mpi_ops_pkg.sv */
// Types shared by the multi-word shift, constant and multiply datapath
`include "mpi_ops_defines.svh"
package mpi_ops_pkg;
  typedef struct packed {
    logic [7:0]         opcode;
    logic [`ADDR_W-1:0] x_operand_pointer;
    logic [`ADDR_W-1:0] y_operand_pointer;
    logic [`ADDR_W-1:0] z_operand_field;
    logic [`ADDR_W-1:0] result_pointer;
    logic [`LEN_W-1:0]  operand_byte_length;
  } cmd_t;
  typedef struct packed {
    logic               rd;
    logic               wr;
    logic [`ADDR_W-1:0] addr;
    logic [63:0]        wdata;
  } ram_req_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_RUN  = 2'h2
  } state_t;
endpackage

/* File: mpi_shift_const_mac_ops.sv */
// Word-serial shift, byte-constant and multiply-accumulate datapath
// Notes on behaviour
// - Opcodes 0x14/0x15 shift left/right, 0x16/0x17 rotate left/right.
// - Shift count is the low six bits of the Z field only.
// - Carry takes the bit moved out; zero updated; result as long as Y.
// - Left shift takes 4*(n+1) cycles, other shifts 4*(n+2).
// - Right shift loads word register with top word << (64 - count), or with the top word itself if count is zero.
// - Rotates load word register from word 0 shifted; rotate right loads top word if count is zero.
// - Config 0x0 or 0x2 means 64-bit words, word count is length>>3.
// - Opcode 0x1A adds byte constant, carry on overflow, zero updated.
// - Opcode 0x1B subtracts byte constant, carry on negative result.
// - Opcodes 0x1D..0x1F: AND/OR/XOR with replicated byte; carry cleared.
// - Shift and constant results are correct written over Y.
// - Opcode 0x20 puts X0*Y0 in word register, no RAM write, 4 cycles.
// - Single-word multiplies ignore length and use one word.
// - Single-word multiplies leave carry and zero unchanged.
// - Opcode 0x24 is carry-less single-word multiply in 4 cycles.
// - Opcode 0x22 computes X0*Y plus carry-extended Z, one word longer.
// - Multiply-accumulate is correct with result over X, Y or Z.
// - 0x26 is carry-less multiply-accumulate; carry cleared, zero updated.
// - GF2 conversion maps 0x22 to 0x26, 0x20 to 0x24, add/sub to 0x1F.
// - Constant ops and multiply-accumulates take 4*(n+1) cycles.
`timescale 1ns/1ps
`include "mpi_ops_defines.svh"
module mpi_shift_const_mac_ops (
  input  wire logic                  clk_sys_i,
  input  wire logic                  resetn_i,
  input  wire logic                  start_i,
  input  wire mpi_ops_pkg::cmd_t     cmd_i,
  input  wire logic                  gf2_conv_i,
  input  wire logic [3:0]            word_size_config_i,
  input  wire logic [63:0]           ram_rdata_i,
  output      mpi_ops_pkg::ram_req_t ram_req_o,
  output      logic [63:0]           word_reg_o,
  output      logic                  carry_o,
  output      logic                  zero_o,
  output      logic                  busy_o,
  output      logic                  done_o,
  output      logic                  cmd_err_o
);

  // Opcode substitution under GF2 conversion
  function automatic logic [7:0] conv_op(input logic [7:0] o,
                                         input logic g);
    conv_op = o;
    if (g) begin
      case (o)
        `OP_MULTIPLY_ACCUMULATE_CARRY:
          conv_op = `OP_CARRYLESS_MULTIPLY_ACCUMULATE;
        `OP_SINGLE_WORD_MULTIPLY: conv_op = `OP_CARRYLESS_WORD_MULTIPLY;
        `OP_ADD_CONST, `OP_SUB_CONST: conv_op = `OP_XOR_CONST;
        default: conv_op = o;
      endcase
    end
  endfunction

  function automatic logic known_op(input logic [7:0] o);
    known_op = ((o >= `OP_SHIFT_LEFT) && (o <= `OP_ROTATE_RIGHT)) ||
               (o == `OP_ADD_CONST) || (o == `OP_SUB_CONST) ||
               ((o >= `OP_AND_CONST) && (o <= `OP_XOR_CONST)) ||
               (o == `OP_SINGLE_WORD_MULTIPLY) ||
               (o == `OP_MULTIPLY_ACCUMULATE_CARRY) ||
               (o == `OP_CARRYLESS_WORD_MULTIPLY) ||
               (o == `OP_CARRYLESS_MULTIPLY_ACCUMULATE);
  endfunction

  function automatic logic op_single(input logic [7:0] o);
    op_single = (o == `OP_SINGLE_WORD_MULTIPLY) ||
                (o == `OP_CARRYLESS_WORD_MULTIPLY);
  endfunction

  function automatic logic op_accum(input logic [7:0] o);
    op_accum = (o == `OP_MULTIPLY_ACCUMULATE_CARRY) ||
               (o == `OP_CARRYLESS_MULTIPLY_ACCUMULATE);
  endfunction

  // Index of the last 4-cycle slot
  function automatic logic [`LEN_W-1:0] slot_last(input logic [7:0] o,
                                                  input logic [`LEN_W-1:0] w);
    if (op_single(o)) slot_last = '0;
    else if ((o >= `OP_SHIFT_RIGHT) && (o <= `OP_ROTATE_RIGHT))
      slot_last = w + 16'h1;
    else slot_last = w;
  endfunction

  function automatic logic [`ADDR_W-1:0] word_addr(
      input logic [`ADDR_W-1:0] b, input logic [`LEN_W-1:0] i);
    word_addr = b + {i[`ADDR_W-4:0], 3'h0};
  endfunction

  function automatic logic [127:0] clmul(input logic [63:0] a,
                                         input logic [63:0] b);
    logic [127:0] acc;
    acc = 128'h0;
    for (int i = 0; i < 64; i++) begin
      if (b[i]) acc = acc ^ ({64'h0, a} << i);
    end
    clmul = acc;
  endfunction

  mpi_ops_pkg::state_t state;
  logic [7:0]          op;
  logic [`ADDR_W-1:0]  yp, zp, rp;
  logic [`LEN_W-1:0]   n, slot, last_slot;
  logic [1:0]          ph;
  logic [63:0]         xw, yw, prev, y0, hi;
  logic                cy, zacc;

  // Command decode
  wire [7:0] start_op = conv_op(cmd_i.opcode, gf2_conv_i);
  wire cfg_ok = (word_size_config_i == `CFG_WORD64_A) ||
                (word_size_config_i == `CFG_WORD64_B);
  wire idle_req = (state == mpi_ops_pkg::ST_IDLE) && start_i;
  wire accept = idle_req && cfg_ok && known_op(start_op);
  wire refuse = idle_req && !(cfg_ok && known_op(start_op));
  wire [`LEN_W-1:0] start_n =
    cmd_i.operand_byte_length >> `WORD_SHIFT;

  wire is_shl  = op == `OP_SHIFT_LEFT;
  wire is_shr  = op == `OP_SHIFT_RIGHT;
  wire is_rotate_left_op = op == `OP_ROTATE_LEFT;
  wire is_rotate_right_op = op == `OP_ROTATE_RIGHT;
  wire is_add  = op == `OP_ADD_CONST;
  wire is_sub  = op == `OP_SUB_CONST;
  wire is_and  = op == `OP_AND_CONST;
  wire is_or   = op == `OP_OR_CONST;
  wire is_xor  = op == `OP_XOR_CONST;
  wire is_mul  = op_single(op);
  wire is_gmul = op == `OP_CARRYLESS_WORD_MULTIPLY;
  wire is_multiply_accumulate_carry = op == `OP_MULTIPLY_ACCUMULATE_CARRY;
  wire is_gmac = op == `OP_CARRYLESS_MULTIPLY_ACCUMULATE;
  wire is_mac  = is_multiply_accumulate_carry || is_gmac;
  wire is_const = is_add || is_sub || is_and || is_or || is_xor;
  wire is_late = is_shr || is_rotate_right_op || is_rotate_left_op;

  wire [5:0] cnt = zp[5:0];
  wire [7:0] kb = zp[7:0];
  wire [6:0] ic = `WORD_BITS - {1'b0, cnt};
  wire [5:0] icl = ic[5:0];
  wire cnt_z = cnt == 6'h0;

  // Slot position
  wire [`LEN_W-1:0] n_m1 = n - 16'h1;
  wire s_first = slot == 16'h0;
  wire s_lt_n = slot < n;
  wire s_top_y = slot == n_m1;
  wire fin = (state == mpi_ops_pkg::ST_RUN) && (ph == `PHASE_LAST) &&
             (slot == last_slot);
  wire rd_y = is_rotate_left_op ? (slot <= n) : (is_mul ? s_first : s_lt_n);
  wire [`LEN_W-1:0] y_idx = is_rotate_left_op ? (s_first ? n_m1 : slot - 16'h1) :
                                      slot;
  wire rd_z = is_mac && s_lt_n;
  wire top_wr = is_mac && (slot == n);
  wire res_v = is_late ? (!s_first && (slot <= n)) :
                         (!is_mul && s_lt_n);
  wire [`LEN_W-1:0] res_idx = is_late ? slot - 16'h1 : slot;

  // Shift and rotate words
  wire [63:0] nxt = s_lt_n ? yw : (is_rotate_right_op ? y0 : 64'h0);
  wire [63:0] shl_r = cnt_z ? yw : (yw << cnt) | (prev >> icl);
  wire [63:0] shr_r = cnt_z ? prev : (prev >> cnt) | (nxt << icl);
  wire out_l = !cnt_z && yw[icl];
  wire out_r = !cnt_z && yw[cnt - 6'h1];

  // Byte-constant arithmetic and logic
  wire [63:0] kword = s_first ? {56'h0, kb} : 64'h0;
  wire        cin = cy && !s_first;
  wire [64:0] sum65 = {1'b0, yw} + {1'b0, kword} + {64'h0, cin};
  wire [64:0] dif65 = {1'b0, yw} - {1'b0, kword} - {64'h0, cin};
  wire [63:0] rep = {8{kb}};

  // Multiplier paths
  wire [127:0] mprod = {64'h0, xw} * {64'h0, yw};
  wire [127:0] clm = clmul(xw, yw);
  wire [127:0] mac128 = mprod + {64'h0, ram_rdata_i} +
                        {64'h0, hi};
  wire [127:0] gmac128 = clm ^ {64'h0, ram_rdata_i ^ hi};
  wire [64:0] top65 = {1'b0, hi} + {64'h0, cy};
  wire [63:0] top_w = is_gmac ? hi : top65[63:0];

  wire [63:0] res = (is_shl || is_rotate_left_op) ? shl_r :
                    (is_shr || is_rotate_right_op) ? shr_r :
                    is_add  ? sum65[63:0] :
                    is_sub  ? dif65[63:0] :
                    is_and  ? (yw & rep) :
                    is_or   ? (yw | rep) :
                    is_xor  ? (yw ^ rep) :
                    is_multiply_accumulate_carry ? mac128[63:0] : gmac128[63:0];

  wire cy_en = (is_shl && s_top_y) || (is_late && s_first) ||
               (is_const && s_lt_n);
  wire cy_val = (is_shl || is_rotate_left_op) ? out_l :
                (is_shr || is_rotate_right_op) ? out_r :
                is_add ? sum65[64] :
                is_sub ? dif65[64] : 1'b0;

  // Word register loads
  wire wreg_en = (is_shr && s_top_y) ||
                 (is_rotate_right_op && s_first && !cnt_z) ||
                 (is_rotate_right_op && s_top_y && cnt_z) ||
                 (is_rotate_left_op && (slot == 16'h1)) ||
                 (is_mul && s_first);
  wire [63:0] wreg_val = is_gmul ? clm[63:0] :
                         is_mul ? mprod[63:0] :
                         is_rotate_left_op ? (yw << cnt) :
                         (cnt_z ? yw : (yw << icl));

  // Sequencer
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state     <= mpi_ops_pkg::ST_IDLE;
      ph        <= 2'h0;
      slot      <= 16'h0;
      busy_o    <= 1'b0;
      done_o    <= 1'b0;
      cmd_err_o <= 1'b0;
    end else begin
      done_o    <= fin;
      cmd_err_o <= refuse;
      case (state)
        mpi_ops_pkg::ST_IDLE: begin
          if (accept) begin
            state  <= mpi_ops_pkg::ST_RUN;
            ph     <= 2'h0;
            slot   <= 16'h0;
            busy_o <= 1'b1;
          end
        end
        mpi_ops_pkg::ST_RUN: begin
          ph <= ph + 2'h1;
          if (ph == `PHASE_LAST) slot <= slot + 16'h1;
          if (fin) begin
            state  <= mpi_ops_pkg::ST_IDLE;
            busy_o <= 1'b0;
          end
        end
        default: state <= mpi_ops_pkg::ST_IDLE;
      endcase
    end
  end

  // Command capture
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      op        <= 8'h0;
      {yp, zp, rp} <= '0;
      n         <= 16'h0;
      last_slot <= 16'h0;
    end else if (accept) begin
      op <= start_op;
      yp <= cmd_i.y_operand_pointer;
      zp <= cmd_i.z_operand_field;
      rp <= cmd_i.result_pointer;
      n  <= op_single(start_op) ? 16'h1 : start_n;
      last_slot <= slot_last(start_op, start_n);
    end
  end

  // Operand words, carry chain and zero accumulation
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {xw, yw, prev, y0, hi} <= '0;
      cy   <= 1'b0;
      zacc <= 1'b0;
    end else if (accept) begin
      prev <= 64'h0;
      hi   <= 64'h0;
      cy   <= carry_o;
      zacc <= 1'b1;
    end else if (state == mpi_ops_pkg::ST_RUN) begin
      if (ph == 2'h1 && s_first) xw <= ram_rdata_i;
      if (ph == 2'h2) yw <= ram_rdata_i;
      if (ph == 2'h1 && top_wr) begin
        cy   <= is_multiply_accumulate_carry && top65[64];
        zacc <= zacc && (top_w == 64'h0);
      end
      if (ph == `PHASE_LAST) begin
        prev <= yw;
        if (s_first) y0 <= yw;
        if (is_multiply_accumulate_carry && s_lt_n) hi <= mac128[127:64];
        if (is_gmac && s_lt_n) hi <= gmac128[127:64];
        if (cy_en) cy <= cy_val;
        if (res_v) zacc <= zacc && (res == 64'h0);
      end
    end
  end

  // Word register and flags
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      word_reg_o <= 64'h0;
      carry_o    <= 1'b0;
      zero_o     <= 1'b0;
    end else begin
      if (ph == `PHASE_LAST && wreg_en && state == mpi_ops_pkg::ST_RUN)
        word_reg_o <= wreg_val;
      if (fin && !is_mul) begin
        carry_o <= cy;
        zero_o  <= zacc;
      end
    end
  end

  // RAM requests; a result word is written before the next operand read
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ram_req_o <= '0;
    end else begin
      ram_req_o <= '0;
      if (accept) begin
        ram_req_o.rd   <= op_single(start_op) || op_accum(start_op);
        ram_req_o.addr <= cmd_i.x_operand_pointer;
      end else if (state == mpi_ops_pkg::ST_RUN) begin
        case (ph)
          2'h0: if (rd_y) begin
            ram_req_o.rd   <= 1'b1;
            ram_req_o.addr <= word_addr(yp, y_idx);
          end
          2'h1: if (rd_z) begin
            ram_req_o.rd   <= 1'b1;
            ram_req_o.addr <= word_addr(zp, slot);
          end else if (top_wr) begin
            ram_req_o.wr    <= 1'b1;
            ram_req_o.addr  <= word_addr(rp, slot);
            ram_req_o.wdata <= top_w;
          end
          2'h3: if (res_v) begin
            ram_req_o.wr    <= 1'b1;
            ram_req_o.addr  <= word_addr(rp, res_idx);
            ram_req_o.wdata <= res;
          end
          default: ;
        endcase
      end
    end
  end

  // Helper state for checks
  logic [`LEN_W+1:0] run_cyc, exp_cyc;
  logic              nz_seen;
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run_cyc <= '0;
      exp_cyc <= '0;
      nz_seen <= 1'b0;
    end else if (accept) begin
      run_cyc <= '0;
      exp_cyc <= {slot_last(start_op, start_n) + 16'h1, 2'h0};
      nz_seen <= 1'b0;
    end else begin
      if (busy_o) run_cyc <= run_cyc + 18'h1;
      if (ram_req_o.wr && ram_req_o.wdata != 64'h0) nz_seen <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  sequence s_single_start;
    accept && op_single(start_op);
  endsequence
  sequence s_four_busy;
    busy_o [*4] ##1 done_o;
  endsequence

  property p_conv;
    idle_req && gf2_conv_i &&
      cmd_i.opcode == `OP_MULTIPLY_ACCUMULATE_CARRY && cfg_ok
      |=> op == `OP_CARRYLESS_MULTIPLY_ACCUMULATE;
  endproperty
  a_conv: assert property (p_conv)
    else $error("conversion opcode not substituted");

  property p_count;
    accept |=> cnt == $past(cmd_i.z_operand_field[5:0]);
  endproperty
  a_count: assert property (p_count)
    else $error("shift count not from low six bits");

  property p_len;
    accept && !op_single(start_op)
      |=> n == ($past(cmd_i.operand_byte_length) >> 3);
  endproperty
  a_len: assert property (p_len)
    else $error("word count not length over eight");

  property p_cycles;
    done_o |-> run_cyc == exp_cyc;
  endproperty
  a_cycles: assert property (p_cycles)
    else $error("operation took wrong number of cycles");

  property p_single_time;
    s_single_start |=> s_four_busy;
  endproperty
  a_single_time: assert property (p_single_time)
    else $error("single-word multiply not four cycles");

  property p_single_flags;
    s_single_start |=> ($stable(carry_o) && $stable(zero_o)) [*5];
  endproperty
  a_single_flags: assert property (p_single_flags)
    else $error("single-word multiply changed flags");

  property p_single_nowr;
    busy_o && is_mul |-> !ram_req_o.wr;
  endproperty
  a_single_nowr: assert property (p_single_nowr)
    else $error("single-word multiply wrote RAM");

  property p_logic_carry;
    done_o && (is_and || is_or || is_xor || is_gmac) |-> !carry_o;
  endproperty
  a_logic_carry: assert property (p_logic_carry)
    else $error("carry not cleared");

  property p_zero;
    done_o && !is_mul |-> zero_o == !nz_seen;
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag disagrees with written words");

endmodule // mpi_shift_const_mac_ops

/* File: mpi_ram_model.sv */
// Operand RAM behind the datapath, one-cycle read latency
`timescale 1ns/1ps
module mpi_ram_model (
  input  wire logic                  clk_sys_i,
  input  wire mpi_ops_pkg::ram_req_t ram_req_i,
  output      logic [63:0]           rdata_o
);
  logic [63:0] mem [0:255];
  int unsigned n_writes = 0;
  initial rdata_o = 64'h0;
  always @(posedge clk_sys_i) begin
    if (ram_req_i.wr) begin
      mem[ram_req_i.addr[10:3]] <= ram_req_i.wdata;
      n_writes++;
    end
    // Data is only valid after a read; otherwise it churns
    if (ram_req_i.rd)
      rdata_o <= mem[ram_req_i.addr[10:3]];
    else
      rdata_o <= ~rdata_o;
  end
endmodule // mpi_ram_model

/* File: mpi_shift_const_mac_ops_test.sv */
// Self-checking bench of the shift, constant and multiply datapath
`timescale 1ns/1ps
module mpi_shift_const_mac_ops_test;
  logic                  clk_sys_i = 1'b0;
  logic                  resetn_i = 1'b0;
  logic                  start_i = 1'b0;
  mpi_ops_pkg::cmd_t     cmd_i = '0;
  logic                  gf2_conv_i = 1'b0;
  logic [3:0]            word_size_config_i = 4'h0;
  logic [63:0]           ram_rdata_i;
  mpi_ops_pkg::ram_req_t ram_req_o;
  logic [63:0]           word_reg_o;
  logic                  carry_o, zero_o, busy_o, done_o, cmd_err_o;
  int                    n_fail = 0, num_checks = 0, n_cyc = 0;
  logic                  e_c = 1'b0, e_z = 1'b0;

  mpi_shift_const_mac_ops dut (.clk_sys_i, .resetn_i, .start_i, .cmd_i,
    .gf2_conv_i, .word_size_config_i, .ram_rdata_i, .ram_req_o, .word_reg_o,
    .carry_o, .zero_o, .busy_o, .done_o, .cmd_err_o);
  mpi_ram_model ram (.clk_sys_i, .ram_req_i(ram_req_o),
    .rdata_o(ram_rdata_i));

  initial forever #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    n_cyc++;
    if (n_cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk_word(input logic [63:0] got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  function automatic logic [127:0] clm(input logic [63:0] a, b);
    logic [127:0] p;
    p = '0;
    for (int i = 0; i < 64; i++) if (b[i]) p ^= {64'h0, a} << i;
    return p;
  endfunction

  // Issue one command at a falling edge and time it to the done pulse
  task automatic run(input logic [7:0] op, input logic gf,
                     input logic [15:0] xp, yp, zf, rp, ln, input int s);
    int cyc;
    cmd_i = '{op, xp, yp, zf, rp, ln};
    gf2_conv_i = gf;
    start_i = 1'b1;
    @(negedge clk_sys_i);
    start_i = 1'b0;
    cyc = 0;
    while (done_o !== 1'b1 && cyc < 300) begin
      cyc++;
      @(negedge clk_sys_i);
    end
    chk_word(64'(cyc), 64'(4 * s), "cycles");
  endtask

  task automatic chk_flags();
    chk_flag(carry_o, e_c, "carry");
    chk_flag(zero_o, e_z, "zero");
  endtask

  task automatic t_shift(input logic [7:0] op, input logic [15:0] zf);
    logic [255:0] y, r;
    logic [63:0]  w;
    int           c;
    y = {128'h0, 64'h9000_0000_0000_0001, 64'h0123_4567_89ab_cdef};
    c = zf[5:0];
    ram.mem[32] = y[63:0];
    ram.mem[33] = y[127:64];
    case (op)
      8'h14: r = y << c;
      8'h15: r = y >> c;
      8'h16: r = (y << c) | (y >> (128 - c));
      default: r = (y >> c) | (y << (128 - c));
    endcase
    r = r & {128'h0, {128{1'b1}}};
    if (op == 8'h14 || op == 8'h16)
      e_c = (c == 0) ? 1'b0 : y[128 - c];
    else
      e_c = (c == 0) ? 1'b0 : y[c - 1];
    e_z = (r == 0);
    run(op, 1'b1, 16'h0, 16'h0100, zf, 16'h0100, 16'h0010,
        (op == 8'h14) ? 3 : 4);
    chk_word(ram.mem[32], r[63:0], "shift r0");
    chk_word(ram.mem[33], r[127:64], "shift r1");
    chk_flags();
    w = (op == 8'h16) ? y[63:0] << c : (c == 0) ? y[127:64] :
        (op == 8'h15) ? y[127:64] << (64 - c) : y[63:0] << (64 - c);
    if (op != 8'h14) chk_word(word_reg_o, w, "shift reg");
    $display("shift test op %h count %0d done", op, c);
  endtask

  task automatic t_const(input logic [7:0] op, input logic gf,
                         input logic [7:0] k, input logic [127:0] y);
    logic [128:0] s;
    logic [127:0] rep;
    logic [7:0]   eop;
    rep = {16{k}};
    eop = (gf && (op == 8'h1a || op == 8'h1b)) ? 8'h1f : op;
    ram.mem[32] = y[63:0];
    ram.mem[33] = y[127:64];
    case (eop)
      8'h1a: s = {1'b0, y} + 129'(k);
      8'h1b: s = {y < 128'(k), y - 128'(k)};
      8'h1d: s = {1'b0, y & rep};
      8'h1e: s = {1'b0, y | rep};
      default: s = {1'b0, y ^ rep};
    endcase
    e_c = s[128];
    e_z = (s[127:0] == 0);
    run(op, gf, 16'h0, 16'h0100, {8'h3c, k}, 16'h0100, 16'h0010, 3);
    chk_word(ram.mem[32], s[63:0], "const r0");
    chk_word(ram.mem[33], s[127:64], "const r1");
    chk_flags();
    $display("const test op %h gf %b done", op, gf);
  endtask

  task automatic t_mul(input logic [7:0] op, input logic gf);
    logic [63:0] x, y, w;
    logic [127:0] p;
    int unsigned nw;
    x = 64'hfedc_ba98_7654_3211;
    y = 64'h1234_5678_9abc_def1;
    ram.mem[0] = x;
    ram.mem[32] = y;
    nw = ram.n_writes;
    p = clm(x, y);
    w = (op == 8'h20 && !gf) ? x * y : p[63:0];
    run(op, gf, 16'h0, 16'h0100, 16'h0, 16'h0300, 16'h0018, 1);
    chk_word(word_reg_o, w, "mul reg");
    chk_word(64'(ram.n_writes - nw), 64'h0, "mul writes");
    chk_flags();
    $display("mul test op %h gf %b done", op, gf);
  endtask

  task automatic t_mac(input logic [7:0] op, input logic gf,
                       input logic [15:0] rp);
    logic [192:0] s;
    logic [63:0]  x;
    logic [127:0] y, z;
    x = 64'hffff_ffff_ffff_ffff;
    y = {128{1'b1}};
    z = {64'h0f0f_0f0f_0f0f_0f0f, 64'hffff_ffff_ffff_ffff};
    ram.mem[0] = x;
    {ram.mem[33], ram.mem[32]} = y;
    {ram.mem[65], ram.mem[64]} = z;
    if (op == 8'h22 && !gf)
      s = 193'(x) * 193'(y) + 193'(z) + (193'(e_c) << 128);
    else
      s = {1'b0, 192'(clm(x, y[63:0])) ^ (192'(clm(x, y[127:64])) << 64)
           ^ 192'(z)};
    e_c = s[192];
    e_z = (s[191:0] == 0);
    word_size_config_i = 4'h2;
    run(op, gf, 16'h0, 16'h0100, 16'h0200, rp, 16'h0010, 3);
    word_size_config_i = 4'h0;
    for (int i = 0; i < 3; i++)
      chk_word(ram.mem[rp[10:3] + i], s[64 * i +: 64], "mac r");
    chk_flags();
    $display("mac test op %h gf %b done", op, gf);
  endtask

  task automatic t_refuse(input logic [7:0] op, input logic [3:0] cfg);
    word_size_config_i = cfg;
    cmd_i.opcode = op;
    start_i = 1'b1;
    @(negedge clk_sys_i);
    start_i = 1'b0;
    word_size_config_i = 4'h0;
    chk_flag(cmd_err_o, 1'b1, "refused err");
    chk_flag(busy_o, 1'b0, "refused busy");
    @(negedge clk_sys_i);
    $display("refuse test op %h cfg %h done", op, cfg);
  endtask

  initial begin
    repeat (8) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    @(negedge clk_sys_i);
    for (int op = 8'h14; op <= 8'h17; op++) begin
      t_shift(8'(op), 16'h0044);
      t_shift(8'(op), 16'h0040);
      t_shift(8'(op), 16'h003f);
    end
    t_const(8'h1a, 1'b0, 8'h01, {128{1'b1}});
    t_const(8'h1d, 1'b0, 8'ha5, {4{32'h1234_5678}});
    t_const(8'h1b, 1'b0, 8'h06, 128'h5);
    t_const(8'h1b, 1'b0, 8'h01, 128'h10);
    t_const(8'h1e, 1'b0, 8'h81, 128'h0);
    t_const(8'h1f, 1'b0, 8'hff, {128{1'b1}});
    t_const(8'h1a, 1'b1, 8'h33, 128'h7);
    t_const(8'h1b, 1'b1, 8'h33, 128'h7);
    t_const(8'h1d, 1'b0, 8'h00, 128'h9);
    t_const(8'h1b, 1'b0, 8'h01, 128'h0);
    t_const(8'h1a, 1'b0, 8'h01, {128{1'b1}});
    t_mac(8'h22, 1'b0, 16'h0200);
    t_mul(8'h20, 1'b0);
    t_mul(8'h20, 1'b1);
    t_mac(8'h22, 1'b1, 16'h0100);
    t_mac(8'h26, 1'b0, 16'h0000);
    t_mul(8'h24, 1'b0);
    t_refuse(8'h14, 4'h1);
    t_refuse(8'h21, 4'h0);
    end_of_test();
  end
endmodule // mpi_shift_const_mac_ops_test
